// File: verilog/mrc_defs.vh
/*
  Constants for the memory reset and mode controller: timing, blink rates,
  selector positions and controller states.
  Assumes a 50 MHz system clock; included by bare name.
*/
`ifndef MRC_DEFS_VH
`define MRC_DEFS_VH

`define MRC_CLK_HZ            50000000
`define MRC_HOLD_MS           3000
`define MRC_WINDOW_MS         3000
`define MRC_HOLD_CYC          (`MRC_CLK_HZ / 1000 * `MRC_HOLD_MS)
`define MRC_WINDOW_CYC        (`MRC_CLK_HZ / 1000 * `MRC_WINDOW_MS)
`define MRC_FAST_HZ           2
`define MRC_SLOW_MHZ          500
`define MRC_FAST_HALF_CYC     (`MRC_CLK_HZ / (2 * `MRC_FAST_HZ))
// Divide before scaling so the 32-bit integer math cannot overflow
`define MRC_SLOW_HALF_CYC     (`MRC_CLK_HZ / 2 / `MRC_SLOW_MHZ * 1000)
`define MRC_CNT_W             28

`define MRC_KEY_RUN           2'h0
`define MRC_KEY_HALT          2'h1
`define MRC_KEY_MEMORY_RESET_KEY_POSITION          2'h2

`define MRC_ST_POWERUP        3'h0
`define MRC_ST_HALT           3'h1
`define MRC_ST_RUN            3'h2
`define MRC_ST_HOLD           3'h3
`define MRC_ST_ARMED          3'h4
`define MRC_ST_WINDOW         3'h5
`define MRC_ST_CLEAR          3'h6

`endif

// File: verilog/mrc_blinker.v
/*
  Halt indicator driver: off, steady on, slow blink or fast blink.
  Assumes mode is steady for a blink period to show a clean rate.
*/
`timescale 1ns/100ps
`include "mrc_defs.vh"

module mrc_blinker #(
  parameter [27:0] FAST_HALF = `MRC_FAST_HALF_CYC,
  parameter [27:0] SLOW_HALF = `MRC_SLOW_HALF_CYC
) (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire [1:0] mode,
  output reg        led_q
);
  // mode: 0 off, 1 steady, 2 slow, 3 fast
  reg  [27:0] cnt_q;
  reg  [1:0]  mode_q;
  wire [27:0] half = (mode == 2'h3) ? FAST_HALF : SLOW_HALF;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q  <= 28'h000_0000;
      mode_q <= 2'h0;
      led_q  <= 1'b0;
    end else begin
      mode_q <= mode;
      if (mode != mode_q) begin
        // Restart phase so a new rate begins with the lamp lit
        cnt_q <= 28'h000_0000;
        led_q <= (mode != 2'h0);
      end else if (mode[1]) begin
        if (cnt_q >= half - 28'h000_0001) begin
          cnt_q <= 28'h000_0000;
          led_q <= ~led_q;
        end else begin
          cnt_q <= cnt_q + 28'h000_0001;
        end
      end else begin
        led_q <= mode[0];
      end
    end
  end
endmodule

// File: verilog/mrc_control.v
/*
  Operating state and memory reset controller of the CPU.
  Watches card presence, selector key and programming device command, raises
  reset requests, runs memory reset and drives the halt indicator.
  Assumes all inputs synchronous to sys_clk; the memory clear engine answers
  clear_start with clear_done.
*/
// Behaviour
// - No run without a memory card
// - Card pulled in run: halt, request reset
// - Card changed while off: auto reset at power-up
// - Fast blink during memory reset
// - Steady halt indicator after reset completes, slow blink if overflow with card re-requests
// - Slow blink while reset request pending
// - Reset clears retentive data, reloads initial blocks
// - Card download keeps retentive areas
// - Request on card swap, RAM error, overflow
// - Request on faulty block load
// - Overflow with card re-requests after each reset
// - Device command accepted only in halt
// - Hold selector: indicator on after hold time
// - Return within window starts reset, fast blink
// - Pending request: brief selector move suffices
`timescale 1ns/100ps
`include "mrc_defs.vh"

module mrc_control #(
  parameter [27:0] HOLD_CYC   = `MRC_HOLD_CYC,
  parameter [27:0] WINDOW_CYC = `MRC_WINDOW_CYC,
  parameter [27:0] FAST_HALF  = `MRC_FAST_HALF_CYC,
  parameter [27:0] SLOW_HALF  = `MRC_SLOW_HALF_CYC
) (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire [1:0] key_position,
  input  wire       card_present,
  input  wire       card_changed,
  input  wire       ram_error,
  input  wire       work_mem_short,
  input  wire       faulty_block_load,
  input  wire       programming_device_reset_cmd,
  input  wire       card_download,
  input  wire       clear_done,
  output reg        clear_start_q,
  output reg        clear_retentive_q,
  output reg        reload_data_block_q,
  output reg        retentive_write_en_q,
  output reg        running_q,
  output reg        reset_request_q,
  output reg        cmd_accepted_q,
  output wire       halt_indicator
);
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [27:0] cnt_q;
  reg         req_set;
  reg         req_clr;
  reg  [1:0]  led_mode;
  wire        key_memory_reset_key_position = (key_position == `MRC_KEY_MEMORY_RESET_KEY_POSITION);
  wire        key_run  = (key_position == `MRC_KEY_RUN);
  wire        cmd_ok   = programming_device_reset_cmd && (state_q == `MRC_ST_HALT);

  // Request causes shared by several states
  function req_cause;
    input pulled;
    begin
      req_cause = pulled | card_changed | ram_error | faulty_block_load;
    end
  endfunction

  always @* begin
    state_d = state_q;
    req_set = 1'b0;
    req_clr = 1'b0;
    case (state_q)
      `MRC_ST_POWERUP: begin
        if (card_changed)
          state_d = `MRC_ST_CLEAR;
        else
          state_d = `MRC_ST_HALT;
      end
      `MRC_ST_HALT: begin
        req_set = req_cause(1'b0) | (work_mem_short & card_present);
        if (cmd_ok)
          state_d = `MRC_ST_CLEAR;
        else if (key_memory_reset_key_position && reset_request_q)
          state_d = `MRC_ST_CLEAR;
        else if (key_memory_reset_key_position)
          state_d = `MRC_ST_HOLD;
        else if (key_run && card_present && !reset_request_q)
          state_d = `MRC_ST_RUN;
      end
      `MRC_ST_RUN: begin
        req_set = req_cause(!card_present) | work_mem_short;
        // Any request cause stops the program; a request raised as halt moves to run stays pending in run
        if (req_set || !key_run)
          state_d = `MRC_ST_HALT;
      end
      `MRC_ST_HOLD: begin
        if (!key_memory_reset_key_position)
          state_d = `MRC_ST_HALT;
        else if (cnt_q >= HOLD_CYC - 28'h000_0001)
          state_d = `MRC_ST_ARMED;
      end
      `MRC_ST_ARMED: begin
        if (!key_memory_reset_key_position)
          state_d = `MRC_ST_WINDOW;
      end
      `MRC_ST_WINDOW: begin
        if (key_memory_reset_key_position)
          state_d = `MRC_ST_CLEAR;
        else if (cnt_q >= WINDOW_CYC - 28'h000_0001)
          state_d = `MRC_ST_HALT;
      end
      `MRC_ST_CLEAR: begin
        if (clear_done) begin
          state_d = `MRC_ST_HALT;
          req_clr = 1'b1;
          // Overflow persists with the same card, so ask again
          req_set = work_mem_short & card_present;
        end
      end
      default: state_d = `MRC_ST_HALT;
    endcase
  end

  always @* begin
    case (state_q)
      `MRC_ST_CLEAR: led_mode = 2'h3;
      `MRC_ST_RUN:   led_mode = 2'h0;
      `MRC_ST_HOLD:  led_mode = 2'h0;
      default:       led_mode = reset_request_q ? 2'h2 : 2'h1;
    endcase
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q              <= `MRC_ST_POWERUP;
      cnt_q                <= 28'h000_0000;
      reset_request_q      <= 1'b0;
      clear_start_q        <= 1'b0;
      clear_retentive_q    <= 1'b0;
      reload_data_block_q  <= 1'b0;
      retentive_write_en_q <= 1'b0;
      running_q            <= 1'b0;
      cmd_accepted_q       <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q)
        cnt_q <= 28'h000_0000;
      else
        cnt_q <= cnt_q + 28'h000_0001;
      // Set wins over clear
      if (req_set)
        reset_request_q <= 1'b1;
      else if (req_clr)
        reset_request_q <= 1'b0;
      clear_start_q       <= (state_d == `MRC_ST_CLEAR) && (state_q != `MRC_ST_CLEAR);
      clear_retentive_q   <= (state_d == `MRC_ST_CLEAR);
      reload_data_block_q <= (state_d == `MRC_ST_CLEAR);
      // Download never opens retentive areas
      retentive_write_en_q <= (state_d == `MRC_ST_CLEAR) && !card_download;
      running_q      <= (state_d == `MRC_ST_RUN) && card_present;
      cmd_accepted_q <= cmd_ok;
    end
  end

  mrc_blinker #(
    .FAST_HALF (FAST_HALF),
    .SLOW_HALF (SLOW_HALF)
  ) mrc_blinker_i (
    .sys_clk (sys_clk),
    .reset   (reset),
    .mode    (led_mode),
    .led_q   (halt_indicator)
  );
endmodule

// File: verif/mrc_control_properties.sv
/*
  Checker: port timing of mrc_control.
  Assumes the bind below, one clock, async high reset.
*/
`timescale 1ns/100ps
module mrc_checks (
  input wire sys_clk,
  input wire reset,
  input wire card_present,
  input wire card_download,
  input wire ram_error,
  input wire faulty_block_load,
  input wire work_mem_short,
  input wire clear_start_q,
  input wire clear_retentive_q,
  input wire reload_data_block_q,
  input wire retentive_write_en_q,
  input wire running_q,
  input wire reset_request_q,
  input wire cmd_accepted_q,
  input wire halt_indicator
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_NO_CARD: assert property (
    running_q && !card_present |-> ##[1:2] !running_q) else $error("run without card");
  AST_PULL_REQ: assert property (
    running_q && !card_present |-> ##[1:3] reset_request_q) else $error("no request");
  AST_REQ_HALT: assert property (
    reset_request_q |-> ##2 !running_q) else $error("run with request");
  AST_CMD_HALT: assert property (
    cmd_accepted_q |-> !$past(running_q)) else $error("command taken in run");
  AST_CLR_LVL: assert property (
    clear_start_q |-> ##[0:1] clear_retentive_q) else $error("no clear level");
  AST_RELOAD: assert property (
    clear_start_q |-> reload_data_block_q) else $error("no reload in clear");
  AST_CLR_WEN: assert property (
    clear_start_q && !$past(card_download) |-> retentive_write_en_q)
    else $error("retentive write closed in clear");
  AST_DL_KEEP: assert property (
    card_download |=> !retentive_write_en_q) else $error("retentive write in download");
  AST_CAUSE: assert property (
    ram_error || faulty_block_load |-> ##[1:3] reset_request_q) else $error("cause ignored");
  AST_FAST: assert property (
    clear_retentive_q [*8] |-> halt_indicator != $past(halt_indicator, 4))
    else $error("no fast blink");
  AST_STEADY: assert property (
    $fell(clear_retentive_q) && !work_mem_short |-> ##3 halt_indicator [*8] ##1 halt_indicator)
    else $error("lamp not steady");
endmodule
bind mrc_control mrc_checks chk_i (.sys_clk, .reset, .card_present, .card_download,
  .ram_error, .faulty_block_load, .work_mem_short, .clear_start_q, .clear_retentive_q,
  .reload_data_block_q, .retentive_write_en_q, .running_q, .reset_request_q,
  .cmd_accepted_q, .halt_indicator);

// File: verif/mrc_partner.sv
/*
  Far side: key selector, programming device, clear engine.
  Assumes bench calls the tasks; changes land at falling edges.
*/
`timescale 1ns/100ps
module mrc_partner (
  input  wire       sys_clk,
  input  wire       clear_start_q,
  output reg  [1:0] key_position,
  output reg        programming_device_reset_cmd,
  output reg        clear_done
);
  initial begin
    key_position = 2'h1;
    programming_device_reset_cmd = 1'h0;
    clear_done = 1'h0;
  end
  // Slow engine so the fast blink is visible
  always @(posedge clear_start_q) begin
    repeat (20) @(negedge sys_clk);
    clear_done = 1'h1;
    @(negedge sys_clk) clear_done = 1'h0;
  end
  task key(input [1:0] p, input integer n); begin
    @(negedge sys_clk) key_position = p;
    repeat (n - 1) @(negedge sys_clk);
  end endtask
  task cmd; begin
    @(negedge sys_clk) programming_device_reset_cmd = 1'h1;
    @(negedge sys_clk) programming_device_reset_cmd = 1'h0;
  end endtask
endmodule

// File: verif/memory_reset_mode_control_tb.sv
/*
  Self-checking bench for mrc_control, counts shortened.
  Assumes mrc_partner and the bound checker.
*/
`timescale 1ns/100ps
module memory_reset_mode_control_tb;
  localparam [1:0] KR = 2'h0;
  localparam [1:0] KH = 2'h1;
  localparam [1:0] KM = 2'h2;
  reg        sys_clk = 1'h0;
  reg        reset = 1'h1;
  reg        card_present = 1'h1;
  reg        card_changed = 1'h1;
  reg        card_download = 1'h0;
  reg  [3:0] cz = 4'h0;
  reg  [7:0] n_clr = 8'h00, n_acc = 8'h00, exp_clr = 8'h00;
  reg        v;
  integer    miscompares = 0, cmp_count = 0, i;
  wire [1:0] key_position;
  wire       programming_device_reset_cmd, clear_done, clear_start_q;
  wire       running_q, reset_request_q, cmd_accepted_q, halt_indicator;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (clear_start_q) n_clr <= n_clr + 8'h01;
    if (cmd_accepted_q) n_acc <= n_acc + 8'h01;
  end
  mrc_control #(.HOLD_CYC(28'h000_0014), .WINDOW_CYC(28'h000_0014),
    .FAST_HALF(28'h000_0004), .SLOW_HALF(28'h000_0008)) mrc_control_i (
    .sys_clk, .reset, .key_position, .card_present, .card_changed(card_changed | cz[2]),
    .ram_error(cz[0]), .faulty_block_load(cz[1]), .work_mem_short(cz[3]),
    .programming_device_reset_cmd,
    .card_download, .clear_done, .clear_start_q, .clear_retentive_q(),
    .reload_data_block_q(), .retentive_write_en_q(), .running_q, .reset_request_q,
    .cmd_accepted_q, .halt_indicator);
  mrc_partner mrc_partner_i (.sys_clk, .clear_start_q, .key_position,
    .programming_device_reset_cmd, .clear_done);
  task chk(input string nm, input [7:0] s, e); begin
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("wrong value %0s exp %h got %h", nm, e, s);
    end
  end endtask
  task wclr(input [7:0] d); begin
    exp_clr = exp_clr + d;
    repeat (40) @(negedge sys_clk);
    chk("clears", n_clr, exp_clr);
  end endtask
  task wrap_up; begin
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end endtask
  task t_pwr; begin
    repeat (4) @(negedge sys_clk);
    reset = 1'h0;
    repeat (6) @(negedge sys_clk);
    card_changed = 1'h0;
    wclr(8'h01);
    chk("lamp", halt_indicator, 1'h1);
    $display("power-up test end");
  end endtask
  task t_run; begin
    mrc_partner_i.key(KR, 4);
    chk("run", running_q, 1'h1);
    card_present = 1'h0;
    repeat (6) @(negedge sys_clk);
    chk("run", running_q, 1'h0);
    chk("req", reset_request_q, 1'h1);
    card_present = 1'h1;
    mrc_partner_i.key(KM, 2);
    mrc_partner_i.key(KH, 2);
    wclr(8'h01);
    chk("req", reset_request_q, 1'h0);
    $display("card test end");
  end endtask
  task t_cmd; begin
    mrc_partner_i.key(KR, 4);
    mrc_partner_i.cmd;
    repeat (3) @(negedge sys_clk);
    chk("acc", n_acc, 8'h00);
    mrc_partner_i.key(KH, 4);
    card_download = 1'h1;
    mrc_partner_i.cmd;
    wclr(8'h01);
    chk("acc", n_acc, 8'h01);
    card_download = 1'h0;
    $display("command test end");
  end endtask
  task t_seq; begin
    mrc_partner_i.key(KM, 10);
    chk("lamp", halt_indicator, 1'h0);
    mrc_partner_i.key(KM, 14);
    chk("lamp", halt_indicator, 1'h1);
    mrc_partner_i.key(KH, 5);
    mrc_partner_i.key(KM, 4);
    mrc_partner_i.key(KH, 1);
    wclr(8'h01);
    mrc_partner_i.key(KM, 24);
    mrc_partner_i.key(KH, 30);
    mrc_partner_i.key(KM, 4);
    mrc_partner_i.key(KH, 1);
    wclr(8'h00);
    $display("selector test end");
  end endtask
  task t_cz; begin
    // Causes in turn: RAM error, faulty block, card swap in halt, short work memory
    for (i = 0; i < 4; i = i + 1) begin
      cz = 4'h1 << i;
      repeat (6) @(negedge sys_clk);
      v = halt_indicator;
      repeat (8) @(negedge sys_clk);
      chk("req", reset_request_q, 1'h1);
      chk("blink", halt_indicator, !v);
      if (i < 3) cz = 4'h0;
      mrc_partner_i.key(KM, 2);
      mrc_partner_i.key(KH, 2);
      wclr(8'h01);
      chk("req", reset_request_q, i == 3);
      cz = 4'h0;
    end
    $display("cause test end");
  end endtask
  initial begin
    t_pwr;
    t_run;
    t_cmd;
    t_seq;
    t_cz;
    wrap_up;
  end
  // Whole run is about 600 cycles
  initial begin
    #200000;
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule
